// [rtl/sep_defs.vh]
// Constants of the serial EEPROM command and status logic
`ifndef SEP_DEFS_VH
`define SEP_DEFS_VH

// ****************************************
// Command opcodes, most significant bit first
// ****************************************
`define SEP_OP_WR_ENABLE  8'h06
`define SEP_OP_WR_DISABLE 8'h04
`define SEP_OP_RD_STATUS  8'h05
`define SEP_OP_WR_STATUS  8'h01
`define SEP_OP_READ       8'h03
`define SEP_OP_WRITE      8'h02

// ****************************************
// Status byte field positions
// ****************************************
`define SEP_SB_WR_PROG    0
`define SEP_SB_WR_LATCH   1
`define SEP_SB_BP_LO      2
`define SEP_SB_BP_HI      3
`define SEP_SB_WR_DIS     7

// ****************************************
// Delivery values of the non-volatile bits
// ****************************************
`define SEP_RST_WR_DIS    1'b0
`define SEP_RST_BP        2'b00

// ****************************************
// Array geometry and protected region bases
// ****************************************
`define SEP_ADDR_W        15
`define SEP_MEM_DEPTH     32768
`define SEP_BASE_QTR      15'h6000
`define SEP_BASE_HALF     15'h4000

// ****************************************
// Timing: self-timed cycle, longest time
// ****************************************
`define SEP_TW_CYCLES     17'h186a0

`endif

// [rtl/sep_eeprom.v]
// Serial EEPROM command, status and array access logic behind SPI pins
`timescale 1ns/10ps
`include "sep_defs.vh"

// Summary of operation
// - Disable opcode waits deselect, then clears latch
// - Latch cleared: reset, disable, write completions
// - Status readable anytime, repeated while selected
// - Busy flag one only during write cycles
// - Latch zero rejects array and status writes
// - Protect bits non-volatile, guard array region
// - Disable bit plus low pin: hardware protection
// - Status write needs prior enable command
// - Status write must end at eighth bit
// - Valid status write starts timed busy cycle
// - New status bits apply after cycle ends
// - Status write keeps low bits; b6-b4 zero
// - Disable bit zero: writable whenever latch set
// - Disable bit one: pin high allows, low rejects
// - Protection entered by either event first
// - Protection left by pin going high or by reset
// - Array read loads address, streams bytes
// - Read address wraps from top to zero
// - Deselect ends read; read while busy ignored
// - Array write ends at byte boundary, starts cycle
// - Busy flag cleared when array cycle ends
// - Bytes MSB first; enable, disable, status decoded
// - Other opcodes decoded; unknown opcode waits
// - Protect pair selects quarter, half or all
// - Address from two bytes, top bit ignored

module sep_eeprom #(
   parameter [16:0] TW_CYCLES = `SEP_TW_CYCLES  // Self-timed cycle length
) (
   input  wire clk_i,        // System clock, 20 MHz
   input  wire reset_i,      // Synchronous reset, active high
   input  wire sclk_i,       // Serial clock from the host
   input  wire cs_n_i,       // Chip select, active low
   input  wire mosi_i,       // Serial data in
   input  wire wp_n_i,       // Write protect, active low
   output wire miso_o,       // Serial data out
   output wire miso_oe_n_o   // Output enable of miso, low drives
);

   // ****************************************
   // State codes, one-hot
   // ****************************************
   localparam [6:0] ST_DESEL = 7'h01;  // Waiting for a select edge
   localparam [6:0] ST_OPC   = 7'h02;  // Shifting in the opcode
   localparam [6:0] ST_ADDR  = 7'h04;  // Shifting in address bytes
   localparam [6:0] ST_DATA  = 7'h08;  // Shifting in data bytes
   localparam [6:0] ST_READ  = 7'h10;  // Streaming array bytes
   localparam [6:0] ST_READ_STATUS_CMD  = 7'h20;  // Streaming the status byte
   localparam [6:0] ST_WAIT  = 7'h40;  // Ignoring input until deselect

   // ****************************************
   // Storage and registers
   // ****************************************
   reg  [7:0]              mem [0:`SEP_MEM_DEPTH-1]; // Array cells
   reg  [2:0]              sclk_pipe_reg;   // Clock synchroniser + delay
   reg  [2:0]              cs_pipe_reg;     // Select synchroniser + delay
   reg  [1:0]              mosi_pipe_reg;   // Data synchroniser
   reg  [1:0]              wp_pipe_reg;     // Protect pin synchroniser
   reg  [6:0]              state_reg;       // Command state
   reg  [2:0]              bit_cnt_reg;     // Bit within input byte
   reg  [7:0]              in_shift_reg;    // Input shifter
   reg  [7:0]              cmd_reg;         // Opcode of this frame
   reg                     addr_hi_reg;     // High address byte seen
   reg  [`SEP_ADDR_W-1:0]  addr_reg;        // Read/write address
   reg  [1:0]              data_cnt_reg;    // Full bytes, saturating
   reg  [7:0]              data_buf_reg;    // Last full data byte
   reg  [`SEP_ADDR_W-1:0]  wr_addr_reg;     // Address of pending write
   reg  [7:0]              wr_data_reg;     // Byte of pending write
   reg                     pend_status_reg; // Pending cycle is status
   reg                     wip_reg;         // Write in progress
   reg                     wel_reg;         // Write enable latch
   reg                     swd_reg;         // Status write disable
   reg  [1:0]              bp_reg;          // Block protect hi/lo
   reg  [16:0]             tw_cnt_reg;      // Self-timed cycle counter
   reg  [7:0]              out_shift_reg;   // Output shifter
   reg  [2:0]              out_cnt_reg;     // Bit within output byte
   reg                     miso_reg;        // Serial output bit
   reg                     oe_n_reg;        // Output enable, low drives

   // ****************************************
   // Derived signals
   // ****************************************
   wire       sclk_rise;     // Rising serial clock edge
   wire       sclk_fall;     // Falling serial clock edge
   wire       cs_fall;       // Select asserted
   wire       cs_rise;       // Select released
   wire       selected;      // Select level, synchronised
   wire       mosi_s;        // Serial data, synchronised
   wire       wp_n_s;        // Protect pin, synchronised
   wire [7:0] in_byte;       // Byte completed by this edge
   wire       hw_protect;    // Hardware protected mode
   wire [7:0] status_byte;   // Status as read by the host
   wire       commit;        // Last cycle of the self-timed write
   wire       at_boundary;   // No partial byte shifted in

   assign sclk_rise = sclk_pipe_reg[1] & ~sclk_pipe_reg[2];
   assign sclk_fall = ~sclk_pipe_reg[1] & sclk_pipe_reg[2];
   assign cs_fall   = ~cs_pipe_reg[1] & cs_pipe_reg[2];
   assign cs_rise   = cs_pipe_reg[1] & ~cs_pipe_reg[2];
   assign selected  = ~cs_pipe_reg[1];
   assign mosi_s    = mosi_pipe_reg[1];
   assign wp_n_s    = wp_pipe_reg[1];
   assign in_byte   = {in_shift_reg[6:0], mosi_s};
   assign at_boundary = (bit_cnt_reg == 3'h0);

   // Either order of events enters it; the pin going high or a reset leaves it
   assign hw_protect = swd_reg & ~wp_n_s;
   // Bits six to four are hard zeros
   assign status_byte = {swd_reg, 3'h0, bp_reg, wel_reg, wip_reg};

   // Final cycle of the self-timed write
   assign commit = wip_reg & (tw_cnt_reg == (TW_CYCLES - 17'h1));
   assign miso_o      = miso_reg;
   assign miso_oe_n_o = oe_n_reg;

   // ****************************************
   // Region guarded by the protect pair
   // ****************************************
   function sep_prot;
      input [1:0]             bp;
      input [`SEP_ADDR_W-1:0] a;
      begin
         case (bp)
            2'b01:   sep_prot = (a >= `SEP_BASE_QTR);
            2'b10:   sep_prot = (a >= `SEP_BASE_HALF);
            2'b11:   sep_prot = 1'b1;
            default: sep_prot = 1'b0;
         endcase
      end
   endfunction

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // Third stage of clock and select is only an edge history
   always @(posedge clk_i) begin
      if (reset_i) begin
         sclk_pipe_reg <= 3'h0;
         cs_pipe_reg   <= 3'h7;
         mosi_pipe_reg <= 2'h0;
         wp_pipe_reg   <= 2'h3;
      end else begin
         sclk_pipe_reg <= {sclk_pipe_reg[1:0], sclk_i};
         cs_pipe_reg   <= {cs_pipe_reg[1:0], cs_n_i};
         mosi_pipe_reg <= {mosi_pipe_reg[0], mosi_i};
         wp_pipe_reg   <= {wp_pipe_reg[0], wp_n_i};
      end
   end

   // ****************************************
   // Array cells
   // ****************************************
   // Cells are written only at the end of the timed cycle
   always @(posedge clk_i) begin
      if (commit & ~pend_status_reg) begin
         mem[wr_addr_reg] <= wr_data_reg;
      end
   end

   // ****************************************
   // Command engine, status and timed cycle
   // ****************************************
   always @(posedge clk_i) begin
      if (reset_i) begin
         state_reg       <= ST_DESEL;
         bit_cnt_reg     <= 3'h0;
         in_shift_reg    <= 8'h00;
         cmd_reg         <= 8'h00;
         addr_hi_reg     <= 1'b0;
         addr_reg        <= 15'h0000;
         data_cnt_reg    <= 2'h0;
         data_buf_reg    <= 8'h00;
         wr_addr_reg     <= 15'h0000;
         wr_data_reg     <= 8'h00;
         pend_status_reg <= 1'b0;
         wip_reg         <= 1'b0;
         wel_reg         <= 1'b0;
         swd_reg         <= `SEP_RST_WR_DIS;
         bp_reg          <= `SEP_RST_BP;
         tw_cnt_reg      <= 17'h00000;
         out_shift_reg   <= 8'h00;
         out_cnt_reg     <= 3'h0;
         miso_reg        <= 1'b0;
         oe_n_reg        <= 1'b1;
      end else begin
         // Self-timed cycle; runs on regardless of the pins
         if (commit) begin
            wip_reg    <= 1'b0;
            wel_reg    <= 1'b0;
            tw_cnt_reg <= 17'h00000;
            if (pend_status_reg) begin
               // Protection bits change only now
               swd_reg <= wr_data_reg[`SEP_SB_WR_DIS];
               bp_reg  <= {wr_data_reg[`SEP_SB_BP_HI],
                           wr_data_reg[`SEP_SB_BP_LO]};
            end
         end else if (wip_reg) begin
            tw_cnt_reg <= tw_cnt_reg + 17'h1;
         end

         if (cs_rise) begin
            // Deselect ends any frame at any point
            state_reg    <= ST_DESEL;
            oe_n_reg     <= 1'b1;
            bit_cnt_reg  <= 3'h0;
            addr_hi_reg  <= 1'b0;
            data_cnt_reg <= 2'h0;
            // Placed after the timed block so a set wins
            case (cmd_reg)
               `SEP_OP_WR_ENABLE, `SEP_OP_WR_DISABLE: begin
                  // Counts only when nothing followed the opcode
                  if (state_reg == ST_WAIT && at_boundary &&
                      data_cnt_reg == 2'h0) begin
                     wel_reg <= (cmd_reg == `SEP_OP_WR_ENABLE);
                  end
               end
               `SEP_OP_WR_STATUS: begin
                  // Exactly one byte, latch set, not protected
                  if (state_reg == ST_DATA && at_boundary &&
                      data_cnt_reg == 2'h1 &&
                      wel_reg && !wip_reg &&
                      !hw_protect) begin
                     wip_reg         <= 1'b1;
                     pend_status_reg <= 1'b1;
                     wr_data_reg     <= data_buf_reg;
                     tw_cnt_reg      <= 17'h00000;
                  end
               end
               `SEP_OP_WRITE: begin
                  if (state_reg == ST_DATA && at_boundary &&
                      data_cnt_reg != 2'h0 &&
                      wel_reg && !wip_reg &&
                      !sep_prot(bp_reg, addr_reg)) begin
                     wip_reg         <= 1'b1;
                     pend_status_reg <= 1'b0;
                     wr_addr_reg     <= addr_reg;
                     wr_data_reg     <= data_buf_reg;
                     tw_cnt_reg      <= 17'h00000;
                  end
               end
               default: ;  // Reads and unknown opcodes leave nothing
            endcase
         end else if (cs_fall && state_reg == ST_DESEL) begin
            // Only a fresh select edge opens a frame
            state_reg   <= ST_OPC;
            bit_cnt_reg <= 3'h0;
         end else if (selected && state_reg != ST_DESEL) begin
            // Input side, sampled on the rising serial edge
            if (sclk_rise) begin
               in_shift_reg <= in_byte;
               bit_cnt_reg  <= bit_cnt_reg + 3'h1;
               if (bit_cnt_reg == 3'h7) begin
                  case (state_reg)
                     ST_OPC: begin
                        cmd_reg <= in_byte;
                        case (in_byte)
                           `SEP_OP_RD_STATUS: begin
                              state_reg     <= ST_READ_STATUS_CMD;
                              out_shift_reg <= status_byte;
                              out_cnt_reg   <= 3'h0;
                           end
                           `SEP_OP_READ, `SEP_OP_WRITE: begin
                              state_reg <= ST_ADDR;
                           end
                           `SEP_OP_WR_STATUS: begin
                              state_reg <= ST_DATA;
                           end
                           default: begin
                              // Enable, disable and unknown codes
                              state_reg <= ST_WAIT;
                           end
                        endcase
                     end
                     ST_ADDR: begin
                        if (!addr_hi_reg) begin
                           // Top bit of the high byte is dropped
                           addr_reg[14:8] <= in_byte[6:0];
                           addr_hi_reg    <= 1'b1;
                        end else begin
                           addr_reg[7:0] <= in_byte;
                           if (cmd_reg != `SEP_OP_READ) begin
                              state_reg <= ST_DATA;
                           end else if (wip_reg) begin
                              state_reg <= ST_WAIT;
                           end else begin
                              state_reg     <= ST_READ;
                              out_shift_reg <=
                                 mem[{addr_reg[14:8], in_byte}];
                              out_cnt_reg   <= 3'h0;
                           end
                        end
                     end
                     ST_DATA, ST_WAIT: begin
                        // Page write keeps the last byte only; extra
                        // bytes in the wait state spoil enable/disable
                        data_buf_reg <= in_byte;
                        if (data_cnt_reg != 2'h3) begin
                           data_cnt_reg <= data_cnt_reg + 2'h1;
                        end
                     end
                     default: ;  // Read states ignore further input
                  endcase
               end
            end
            // Output side, shifted on the falling serial edge
            if (sclk_fall &&
                (state_reg == ST_READ || state_reg == ST_READ_STATUS_CMD)) begin
               miso_reg <= out_shift_reg[7];
               oe_n_reg <= 1'b0;
               if (out_cnt_reg == 3'h7) begin
                  out_cnt_reg <= 3'h0;
                  if (state_reg == ST_READ) begin
                     // Address is 15 bits wide, so it wraps
                     addr_reg      <= addr_reg + 15'h0001;
                     out_shift_reg <= mem[addr_reg + 15'h0001];
                  end else begin
                     // Live status each byte, busy flag included
                     out_shift_reg <= status_byte;
                  end
               end else begin
                  out_shift_reg <= {out_shift_reg[6:0], 1'b0};
                  out_cnt_reg   <= out_cnt_reg + 3'h1;
               end
            end
         end
      end
   end

endmodule

// [tb/sep_eeprom_props.sv]
// Checker of the serial EEPROM pin behaviour
`timescale 1ns/10ps
`include "sep_defs.vh"
module sep_eeprom_props #(
   parameter [16:0] TW_CYCLES = 17'h00014 // Timed cycle length
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   input wire logic wp_n_i,
   input wire logic miso_o,
   input wire logic miso_oe_n_o
);
   reg       sclk_q;   // Serial clock one sample ago
   reg [5:0] rise_cnt; // Serial clock rises in this frame
   reg [7:0] op_q;     // Opcode as it shifts in
   reg [2:0] high_cnt; // Samples with serial clock high
   // ****************************************
   // Pin-level frame tracker
   // ****************************************
   // Count saturates so a long read stream cannot wrap it
   always @(posedge clk_i) begin
      sclk_q <= sclk_i;
      if (reset_i || cs_n_i) begin
         rise_cnt <= 6'h00;
      end else if (sclk_i && !sclk_q && rise_cnt != 6'h3f) begin
         rise_cnt <= rise_cnt + 6'h01;
         if (rise_cnt < 6'h08) begin
            op_q <= {op_q[6:0], mosi_i};
         end
      end
      if (!sclk_i) begin
         high_cnt <= 3'h0;
      end else if (high_cnt != 3'h7) begin
         high_cnt <= high_cnt + 3'h1;
      end
   end
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   sequence s_deselect;
      $rose(cs_n_i);
   endsequence
   sequence s_idle;
      cs_n_i [*6];
   endsequence
   AST_RESET_FLOAT: assert property (
      $fell(reset_i) |-> miso_oe_n_o && !miso_o)
      else $error("miso driven after reset");
   AST_RELEASE_ON_DESELECT: assert property (
      s_deselect |-> ##[1:5] miso_oe_n_o)
      else $error("miso not released after deselect");
   AST_FLOAT_WHILE_IDLE: assert property (
      s_idle |-> miso_oe_n_o)
      else $error("miso driven while deselected");
   AST_DRIVE_AT_FALL: assert property (
      $fell(miso_oe_n_o) |-> !cs_n_i && high_cnt < 3'h2)
      else $error("miso drive began off a falling edge");
   AST_FIRST_BIT_AFTER_HEADER: assert property (
      $fell(miso_oe_n_o) |->
         (op_q == `SEP_OP_RD_STATUS && rise_cnt == 6'h08) ||
         (op_q == `SEP_OP_READ && rise_cnt == 6'h18))
      else $error("miso drive began at a wrong bit count");
   AST_MISO_MOVES_ON_FALL: assert property (
      $changed(miso_o) && !miso_oe_n_o |-> high_cnt < 3'h2)
      else $error("miso moved while serial clock high");
   AST_MISO_HOLDS_HIGH: assert property (
      high_cnt >= 3'h4 && !miso_oe_n_o |-> $stable(miso_o))
      else $error("miso unstable in high clock phase");
   AST_OE_HOLDS_IN_FRAME: assert property (
      !miso_oe_n_o && !cs_n_i |=> !miso_oe_n_o)
      else $error("miso released inside a frame");
endmodule

bind sep_eeprom sep_eeprom_props #(
   .TW_CYCLES(TW_CYCLES)
) sep_eeprom_props_i (
   .clk_i(clk_i),
   .reset_i(reset_i),
   .sclk_i(sclk_i),
   .cs_n_i(cs_n_i),
   .mosi_i(mosi_i),
   .wp_n_i(wp_n_i),
   .miso_o(miso_o),
   .miso_oe_n_o(miso_oe_n_o)
);

// [tb/sep_spi_host.sv]
// Behavioural SPI host, mode 0, that frames commands
`timescale 1ns/10ps
module sep_spi_host (
   input  wire logic clk_i,       // System clock
   input  wire logic miso_i,      // Serial data from the device
   input  wire logic miso_oe_n_i, // Device drive enable, low drives
   output logic      sclk_o,      // Serial clock, still between frames
   output logic      cs_n_o,      // Chip select, active low
   output logic      mosi_o       // Serial data to the device
);
   logic miso_last = 1'b0; // Last level the device drove
   logic drove     = 1'b0; // Device drove miso in this frame
   logic cs_q      = 1'b1; // Select one clock ago, finds frame starts
   // A released line shows no trustworthy level, so invert the last one
   wire  miso_line = miso_oe_n_i ? ~miso_last : miso_i;
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // Flag cleared at each select edge so it covers one frame only
   always @(posedge clk_i) begin
      cs_q <= cs_n_o;
      if (!miso_oe_n_i) begin
         miso_last <= miso_i;
         drove     <= 1'b1;
      end else if (cs_q && !cs_n_o) begin
         drove <= 1'b0;
      end
   end
   task sel();
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask
   // Rise of select lands between the last rise and the next one
   task desel();
      repeat (4) @(posedge clk_i);
      cs_n_o <= 1'b1;
      mosi_o <= ~mosi_o;
      repeat (8) @(posedge clk_i);
   endtask
   // Half period of 4 clocks; miso taken just before each rise
   task xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nb && i >= 0; i--) begin
         mosi_o <= tx[i];
         repeat (4) @(posedge clk_i);
         rx[i] = miso_line;
         sclk_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b0;
      end
   endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench of the serial EEPROM command logic
`timescale 1ns/10ps
`include "sep_defs.vh"
module testbench;
   // Short timed cycle: busy stays visible for a few polls
   localparam [16:0] TW = 17'h00190;
   typedef struct packed {
      logic       wp; // Write protect pin level
      logic       en; // Send write enable first
      logic [7:0] d;  // Status byte written
      logic [7:0] ex; // Status read back afterwards
   } sep_row_t;
   sep_row_t rows [8] = '{
      '{1'b1, 1'b0, 8'h8c, 8'h00}, '{1'b0, 1'b1, 8'h7f, 8'h0c},
      '{1'b1, 1'b1, 8'h84, 8'h84}, '{1'b0, 1'b1, 8'h00, 8'h86},
      '{1'b1, 1'b0, 8'h08, 8'h08}, '{1'b0, 1'b1, 8'h88, 8'h88},
      '{1'b0, 1'b1, 8'h00, 8'h8a}, '{1'b1, 1'b0, 8'h00, 8'h00}};
   logic [15:0] pa [6] = '{16'h5fff, 16'h6000, 16'h3fff,
                           16'h4000, 16'h0000, 16'h7fff};
   logic        clk_i   = 1'b0;
   logic        reset_i = 1'b1;
   logic        wp_n_i  = 1'b1;
   wire         sclk_i, cs_n_i, mosi_i, miso_o, miso_oe_n_o;
   logic [7:0]  r, s, q0, q1, prev;
   logic [1:0]  bp;
   logic        lat, acc;
   int          n_errors = 0;
   int          tests_run = 0;
   int          cyc = 0;
   always #25 clk_i = ~clk_i;
   sep_eeprom #(.TW_CYCLES(TW)) sep_eeprom_i (.clk_i(clk_i),
      .reset_i(reset_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
      .mosi_i(mosi_i), .wp_n_i(wp_n_i), .miso_o(miso_o),
      .miso_oe_n_o(miso_oe_n_o));
   sep_spi_host sep_spi_host_i (.clk_i(clk_i), .miso_i(miso_o),
      .miso_oe_n_i(miso_oe_n_o), .sclk_o(sclk_i), .cs_n_o(cs_n_i),
      .mosi_o(mosi_i));
   // ****************************************
   // Checking and closing
   // ****************************************
   task check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task print_verdict();
      $display("Checks %0d, errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Hang guard, well above the expected run length
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_errors++;
         print_verdict();
      end
   end
   // ****************************************
   // Frame tasks
   // ****************************************
   task op1(input logic [7:0] op);
      sep_spi_host_i.sel();
      sep_spi_host_i.xfer(op, 8, r);
      sep_spi_host_i.desel();
   endtask
   task write_status_cmd(input logic [7:0] d);
      sep_spi_host_i.sel();
      sep_spi_host_i.xfer(`SEP_OP_WR_STATUS, 8, r);
      sep_spi_host_i.xfer(d, 8, r);
      sep_spi_host_i.desel();
   endtask
   // Status byte read twice in one frame
   task read_status_cmd(output logic [7:0] st);
      logic [7:0] again;
      sep_spi_host_i.sel();
      sep_spi_host_i.xfer(`SEP_OP_RD_STATUS, 8, r);
      sep_spi_host_i.xfer(8'hff, 8, st);
      sep_spi_host_i.xfer(8'hff, 8, again);
      sep_spi_host_i.desel();
      if (!st[0]) check(again, st);
   endtask
   // Opcode, two address bytes, one data byte, a second on reads
   task arr(input logic [7:0] op, input logic [15:0] a,
            input logic [7:0] d);
      sep_spi_host_i.sel();
      sep_spi_host_i.xfer(op, 8, r);
      sep_spi_host_i.xfer(a[15:8], 8, r);
      sep_spi_host_i.xfer(a[7:0], 8, r);
      sep_spi_host_i.xfer(d, 8, q0);
      if (op == `SEP_OP_READ) sep_spi_host_i.xfer(8'hff, 8, q1);
      sep_spi_host_i.desel();
   endtask
   // Poll until idle; the first status seen is returned
   task settle(output logic [7:0] first);
      logic [7:0] st;
      read_status_cmd(first);
      st = first;
      for (int k = 0; k < 20 && st[0]; k++) read_status_cmd(st);
      check({7'h00, st[0]}, 8'h00);
   endtask
   function automatic logic prot(input logic [1:0] b, input logic [15:0] a);
      return b == 2'b11 || (b == 2'b10 && a[14:0] >= `SEP_BASE_HALF) ||
             (b == 2'b01 && a[14:0] >= `SEP_BASE_QTR);
   endfunction
   initial begin
      repeat (10) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      prev = 8'h00;
      // Protection modes: status busy and old bits first, new after
      foreach (rows[i]) begin
         wp_n_i <= rows[i].wp;
         if (rows[i].en) op1(`SEP_OP_WR_ENABLE);
         lat = prev[1] | rows[i].en;
         acc = lat & (~prev[7] | rows[i].wp);
         write_status_cmd(rows[i].d);
         settle(s);
         check(s, {prev[7:2], lat, acc});
         read_status_cmd(s);
         check(s, rows[i].ex);
         prev = rows[i].ex;
      end
      op1(`SEP_OP_WR_ENABLE);
      read_status_cmd(s);
      check(s, 8'h02);
      op1(`SEP_OP_WR_DISABLE);
      read_status_cmd(s);
      check(s, 8'h00);
      // Top address with the ignored bit set, then wrap to zero
      op1(`SEP_OP_WR_ENABLE);
      arr(`SEP_OP_WRITE, 16'hffff, 8'ha5);
      settle(s);
      check(s, 8'h03);
      op1(`SEP_OP_WR_ENABLE);
      arr(`SEP_OP_WRITE, 16'h0000, 8'h3c);
      settle(s);
      arr(`SEP_OP_READ, 16'h7fff, 8'hff);
      check(q0, 8'ha5);
      check(q1, 8'h3c);
      // Region boundaries of each protect setting
      for (int i = 0; i < 6; i++) begin
         bp = 2'(i / 2 + 1);
         if (i % 2 == 0) begin
            op1(`SEP_OP_WR_ENABLE);
            write_status_cmd({4'h0, bp, 2'b00});
            settle(s);
         end
         op1(`SEP_OP_WR_ENABLE);
         arr(`SEP_OP_WRITE, pa[i], 8'h5a);
         settle(s);
         check(s, {4'h0, bp, 1'b1, ~prot(bp, pa[i])});
      end
      op1(`SEP_OP_WR_ENABLE);
      write_status_cmd(8'h00);
      settle(s);
      arr(`SEP_OP_READ, 16'h7fff, 8'hff);
      check(q0, 8'ha5);
      check(q1, 8'h3c);
      // Read during a timed cycle is ignored
      op1(`SEP_OP_WR_ENABLE);
      arr(`SEP_OP_WRITE, 16'h1234, 8'h77);
      arr(`SEP_OP_READ, 16'h1234, 8'hff);
      check({7'h00, sep_spi_host_i.drove}, 8'h00);
      settle(s);
      arr(`SEP_OP_READ, 16'h1234, 8'hff);
      check(q0, 8'h77);
      arr(8'hab, 16'h0000, 8'hff);
      check({7'h00, sep_spi_host_i.drove}, 8'h00);
      // Status write ending off the byte boundary
      op1(`SEP_OP_WR_ENABLE);
      for (int nb = 7; nb <= 9; nb += 2) begin
         sep_spi_host_i.sel();
         sep_spi_host_i.xfer(`SEP_OP_WR_STATUS, 8, r);
         sep_spi_host_i.xfer(8'h8c, nb, r);
         if (nb > 8) sep_spi_host_i.xfer(8'hff, 1, r);
         sep_spi_host_i.desel();
         read_status_cmd(s);
         check(s, 8'h02);
      end
      // Reset in mid-run returns the delivery status
      op1(`SEP_OP_WR_ENABLE);
      write_status_cmd(8'h8c);
      settle(s);
      reset_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      read_status_cmd(s);
      check(s, 8'h00);
      print_verdict();
   end
endmodule
